/* timer_defs.svh */
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CONTROL   8'h00
`define OFS_COUNT     8'h04
`define OFS_PERIOD    8'h08
`define OFS_IRQ_FLAGS 8'h0c
`define OFS_IRQ_ENAB  8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTL_PRE_LSB   0
`define CTL_PRE_MSB   1
`define CTL_RUN_BIT   2
`define CTL_POST_LSB  3
`define CTL_POST_MSB  6
`define IRQ_MATCH_BIT 1

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RST_CONTROL   7'h00
`define RST_COUNT     8'h00
`define RST_PERIOD    8'hff
`define INSTR_DIV     4
`define PRE_LIM_1     4'h0
`define PRE_LIM_4     4'h3
`define PRE_LIM_16    4'hf

`endif

/* timer_pkg.sv */
package timer_pkg;

  typedef enum logic [1:0] {
    PRE_DIV1  = 2'h0,
    PRE_DIV4  = 2'h1,
    PRE_DIV16 = 2'h2
  } prescale_e;

  typedef logic [7:0] byte_t;

endpackage : timer_pkg

/* period_match_timer_8bit.sv */
// Functional notes
// - running count steps once per prescaled instruction tick
// - count compared with period every cycle
// - match clears count, clocks postscaler
// - reset: count zero, period all ones
// - count or control write clears pre/postscalers
// - control write keeps count value
// - postscale select 0000..1111 gives 1:1..1:16
// - postscaler terminal sets match irq flag
// - irq only when enable bit set
// - control bit 7 reads zero
// - unscaled match output to compare units
// - match output usable as serial shift clock
// - count and period freely read/writable
`timescale 1ns/1ps
`include "timer_defs.svh"

module period_match_timer_8bit import timer_pkg::*; #(
  parameter int INSTR_DIV = `INSTR_DIV
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             match_out,
  output logic             shift_clk_out,
  output logic             irq
);

  localparam int IW = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;
  localparam logic [IW-1:0] INSTR_LAST = IW'(INSTR_DIV - 1);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic [3:0] pre_limit(input logic [1:0] sel);
    pre_limit = (sel == PRE_DIV1) ? `PRE_LIM_1 :
                (sel == PRE_DIV4) ? `PRE_LIM_4 : `PRE_LIM_16;
  endfunction : pre_limit

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [6:0]    control_r;
  byte_t         count_r;
  byte_t         period_r;
  logic          flag_r;
  logic          enable_r;
  logic [IW-1:0] instr_cnt_r;
  logic [3:0]    pre_cnt_r;
  logic [3:0]    post_cnt_r;
  logic [31:0]   prdata_r;
  logic          match_r;
  logic          shift_r;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire setup      = psel && !penable;
  wire access     = psel && penable;
  wire wr_acc     = access && pwrite;
  wire rd_acc     = access && !pwrite;
  wire mapped     = hit(paddr, `OFS_CONTROL) || hit(paddr, `OFS_COUNT) ||
                    hit(paddr, `OFS_PERIOD) || hit(paddr, `OFS_IRQ_FLAGS) ||
                    hit(paddr, `OFS_IRQ_ENAB);
  wire wr_ctrl    = wr_acc && hit(paddr, `OFS_CONTROL);
  wire wr_count   = wr_acc && hit(paddr, `OFS_COUNT);
  wire wr_period  = wr_acc && hit(paddr, `OFS_PERIOD);
  wire wr_flags   = wr_acc && hit(paddr, `OFS_IRQ_FLAGS);
  wire wr_enab    = wr_acc && hit(paddr, `OFS_IRQ_ENAB);
  wire rd_ctrl    = rd_acc && hit(paddr, `OFS_CONTROL);
  wire rd_flags   = rd_acc && hit(paddr, `OFS_IRQ_FLAGS);

  // ----------------------------------------
  // timer datapath
  // ----------------------------------------
  wire [1:0] pre_sel    = control_r[`CTL_PRE_MSB:`CTL_PRE_LSB];
  wire [3:0] post_sel   = control_r[`CTL_POST_MSB:`CTL_POST_LSB];
  wire       timer_run  = control_r[`CTL_RUN_BIT];
  wire       instr_tick = timer_run && (instr_cnt_r == INSTR_LAST);
  wire       count_tick = instr_tick && (pre_cnt_r == pre_limit(pre_sel));
  wire       match_now  = (count_r == period_r);
  wire       match_evt  = count_tick && match_now;
  wire       post_evt   = match_evt && (post_cnt_r == post_sel);
  wire       scaler_clr = wr_count || wr_ctrl;
  // only bits already shown to software are cleared by the read
  wire       flag_clr   = (rd_flags && prdata_r[`IRQ_MATCH_BIT]) ||
                          (wr_flags && !pwdata[`IRQ_MATCH_BIT]);

  // instruction clock divider
  always_ff @(posedge clk) begin
    if (srst || !timer_run) begin
      instr_cnt_r <= '0;
    end else begin
      instr_cnt_r <= instr_tick ? '0 : instr_cnt_r + IW'(1);
    end
  end

  // prescaler
  always_ff @(posedge clk) begin
    if (srst || scaler_clr) begin
      pre_cnt_r <= 4'h0;
    end else if (instr_tick) begin
      pre_cnt_r <= count_tick ? 4'h0 : pre_cnt_r + 4'h1;
    end
  end

  // count register, software write wins over a match
  always_ff @(posedge clk) begin
    if (srst) begin
      count_r <= `RST_COUNT;
    end else if (wr_count) begin
      count_r <= pwdata[7:0];
    end else if (count_tick) begin
      count_r <= match_now ? 8'h00 : count_r + 8'h01;
    end
  end

  // postscaler
  always_ff @(posedge clk) begin
    if (srst || scaler_clr) begin
      post_cnt_r <= 4'h0;
    end else if (match_evt) begin
      post_cnt_r <= post_evt ? 4'h0 : post_cnt_r + 4'h1;
    end
  end

  // control, period, enable
  always_ff @(posedge clk) begin
    if (srst) begin
      control_r <= `RST_CONTROL;
      period_r  <= `RST_PERIOD;
      enable_r  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        control_r <= pwdata[6:0];
      end
      if (wr_period) begin
        period_r <= pwdata[7:0];
      end
      if (wr_enab) begin
        enable_r <= pwdata[`IRQ_MATCH_BIT];
      end
    end
  end

  // sticky flag, a set beats a clear
  always_ff @(posedge clk) begin
    if (srst) begin
      flag_r <= 1'b0;
    end else if (post_evt) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  // match pulse and shift clock
  always_ff @(posedge clk) begin
    if (srst) begin
      match_r <= 1'b0;
      shift_r <= 1'b0;
    end else begin
      match_r <= match_evt;
      shift_r <= shift_r ^ match_evt;
    end
  end

  // ----------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------
  wire [31:0] rd_mux =
    hit(paddr, `OFS_CONTROL)   ? {25'h0, control_r} :
    hit(paddr, `OFS_COUNT)     ? {24'h0, count_r} :
    hit(paddr, `OFS_PERIOD)    ? {24'h0, period_r} :
    hit(paddr, `OFS_IRQ_FLAGS) ? {30'h0, flag_r, 1'b0} :
    hit(paddr, `OFS_IRQ_ENAB)  ? {30'h0, enable_r, 1'b0} : 32'h0;

  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_r <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  assign pready        = 1'b1;
  assign pslverr       = access && !mapped;
  assign prdata        = prdata_r;
  assign match_out     = match_r;
  assign shift_clk_out = shift_r;
  assign irq           = flag_r && enable_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_count_step: assert property (@(posedge clk) disable iff (srst)
    count_tick && !match_now && !wr_count |=> count_r == $past(count_r) + 8'h01)
    else $error("count did not step on tick");

  a_pre_div16: assert property (@(posedge clk) disable iff (srst)
    instr_tick && pre_sel[1] && !scaler_clr |=> pre_cnt_r == $past(pre_cnt_r) + 4'h1)
    else $error("divide by sixteen prescale wrong");

  a_pre_div4: assert property (@(posedge clk) disable iff (srst)
    pre_sel == 2'b01 |-> pre_cnt_r <= 4'h3)
    else $error("divide by four prescale overran");

  a_pre_div1: assert property (@(posedge clk) disable iff (srst)
    pre_sel == 2'b00 |-> pre_cnt_r == 4'h0)
    else $error("divide by one prescale moved");

  a_match_wrap: assert property (@(posedge clk) disable iff (srst)
    match_evt && !wr_count |=> count_r == 8'h00)
    else $error("count not cleared after match");

  a_match_level: assert property (@(posedge clk) disable iff (srst)
    count_tick && (count_r != period_r) |=> !match_out)
    else $error("match output without equality");

  a_reset_vals: assert property (@(posedge clk)
    srst |=> count_r == 8'h00 && period_r == 8'hff && post_cnt_r == 4'h0)
    else $error("reset values wrong");

  a_scaler_clr: assert property (@(posedge clk) disable iff (srst)
    scaler_clr |=> pre_cnt_r == 4'h0 && post_cnt_r == 4'h0)
    else $error("scalers not cleared by write");

  a_ctrl_keeps: assert property (@(posedge clk) disable iff (srst)
    wr_ctrl && !count_tick |=> count_r == $past(count_r))
    else $error("control write disturbed count");

  a_off_hold: assert property (@(posedge clk) disable iff (srst)
    !timer_run && !wr_count && !wr_ctrl |=> $stable(count_r) && $stable(post_cnt_r) && !match_out)
    else $error("stopped timer moved");

  a_post_div: assert property (@(posedge clk) disable iff (srst)
    post_evt |-> post_cnt_r == post_sel && match_evt)
    else $error("postscale terminal wrong");

  a_flag_set: assert property (@(posedge clk) disable iff (srst)
    post_evt |=> flag_r)
    else $error("flag not set by postscaler");

  a_irq_gate: assert property (@(posedge clk) disable iff (srst)
    irq |-> enable_r && flag_r)
    else $error("irq without enable");

  a_bit7_zero: assert property (@(posedge clk) disable iff (srst)
    rd_ctrl |-> prdata[7] == 1'b0)
    else $error("control bit 7 read as one");

  a_unscaled_out: assert property (@(posedge clk) disable iff (srst)
    match_evt |=> match_out ##1 !match_out || $past(match_evt))
    else $error("match output not a pulse");

  a_shift_toggle: assert property (@(posedge clk) disable iff (srst)
    match_evt |=> shift_clk_out != $past(shift_clk_out))
    else $error("shift clock did not toggle");

  a_period_wr: assert property (@(posedge clk) disable iff (srst)
    wr_period |=> period_r == $past(pwdata[7:0]))
    else $error("period write lost");

  a_flag_sticky: assert property (@(posedge clk) disable iff (srst)
    flag_r && !flag_clr |=> flag_r)
    else $error("flag dropped without clear");

  a_flag_wr_clr: assert property (@(posedge clk) disable iff (srst)
    wr_flags && !pwdata[`IRQ_MATCH_BIT] && !post_evt |=> !flag_r)
    else $error("flag not cleared by write of zero");

  a_flag_rd_clr: assert property (@(posedge clk) disable iff (srst)
    rd_flags && prdata_r[`IRQ_MATCH_BIT] && !post_evt |=> !flag_r)
    else $error("flag not cleared by read");

  a_irq_level: assert property (@(posedge clk) disable iff (srst)
    flag_r && enable_r |-> irq)
    else $error("irq low with enabled flag");

  a_post_range: assert property (@(posedge clk) disable iff (srst)
    post_cnt_r <= post_sel)
    else $error("postscaler beyond selected count");

  a_count_wr: assert property (@(posedge clk) disable iff (srst)
    wr_count |=> count_r == $past(pwdata[7:0]))
    else $error("count write lost");

  a_off_quiet: assert property (@(posedge clk) disable iff (srst)
    !timer_run |-> !match_evt && !post_evt)
    else $error("event while stopped");

  a_ctrl_write: assert property (@(posedge clk) disable iff (srst)
    wr_ctrl |=> control_r == $past(pwdata[6:0]))
    else $error("control write lost");

endmodule : period_match_timer_8bit

/* pwm_base_watch.sv */
`timescale 1ns/1ps
// ----------------------------------------
// far side: pwm time base and shift clock user
// ----------------------------------------
module pwm_base_watch (
  input wire logic clk,
  input wire logic srst,
  input wire logic match_out,
  input wire logic shift_clk_out
);
  int   cyc;
  int   last;
  int   gap;
  int   match_cnt;
  int   toggles;
  int   shift_err;
  logic shift_q;
  always @(posedge clk) begin
    cyc++;
    if (srst) begin
      match_cnt = 0;
      toggles   = 0;
      shift_q   = shift_clk_out;
    end else begin
      if (match_out === 1'b1) begin
        gap       = cyc - last;
        last      = cyc;
        match_cnt = match_cnt + 1;
      end
      if (shift_clk_out !== shift_q) begin
        toggles++;
      end
      shift_q = shift_clk_out;
      if (toggles > match_cnt + 1 || match_cnt > toggles + 1) begin
        shift_err++;
      end
    end
  end
endmodule : pwm_base_watch

/* tb_top.sv */
`timescale 1ns/1ps
`include "timer_defs.svh"
module tb_top;
  localparam int IDIV = 2;
  logic        clk     = 1'b0;
  logic        srst    = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] v;
  logic        pready;
  logic        pslverr;
  logic        se;
  logic        match_out;
  logic        shift_clk_out;
  logic        irq;
  int          err_total = 0;
  int          checks    = 0;
  int          cyc       = 0;
  int          p;
  int          post;
  int          b;
  int          dv[4]     = '{1, 4, 16, 16};
  int unsigned seed      = 51985;

  period_match_timer_8bit #(.INSTR_DIV(IDIV)) period_match_timer_8bit_inst (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .match_out(match_out), .shift_clk_out(shift_clk_out), .irq(irq));
  pwm_base_watch pwm_base_watch_inst (
    .clk(clk), .srst(srst), .match_out(match_out), .shift_clk_out(shift_clk_out));

  initial forever #12.5 clk = ~clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic tally_and_finish();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_v

  task automatic chk_n(input int got, input int exp);
    checks++;
    if (got != exp) begin
      err_total++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_n

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_v(rd, exp);
  endtask : rdc

  task automatic wait_m(input int n);
    int s;
    s = pwm_base_watch_inst.match_cnt;
    while (pwm_base_watch_inst.match_cnt < s + n) @(negedge clk);
  endtask : wait_m

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rdc(`OFS_CONTROL, 32'h0);
    rdc(`OFS_COUNT, 32'h0);
    rdc(`OFS_PERIOD, 32'hff);
    apb(1'b1, `OFS_CONTROL, 32'hff);
    rdc(`OFS_CONTROL, 32'h7f);
    apb(1'b1, `OFS_CONTROL, 32'h0);
    for (int c = 0; c < 4; c++) begin
      p = int'(rnd() % 6) + 1;
      apb(1'b1, `OFS_PERIOD, 32'(p));
      rdc(`OFS_PERIOD, 32'(p));
      apb(1'b1, `OFS_COUNT, 32'h0);
      apb(1'b1, `OFS_CONTROL, 32'(4 | c));
      wait_m(2);
      chk_n(pwm_base_watch_inst.gap, (p + 1) * dv[c] * IDIV);
    end
    post = int'(rnd() % 4);
    apb(1'b1, `OFS_IRQ_ENAB, 32'h2);
    apb(1'b1, `OFS_CONTROL, 32'h0);
    apb(1'b1, `OFS_IRQ_FLAGS, 32'h0);
    b = pwm_base_watch_inst.match_cnt;
    apb(1'b1, `OFS_CONTROL, 32'(post << 3 | 4));
    while (irq !== 1'b1) @(negedge clk);
    @(negedge clk);
    chk_n(pwm_base_watch_inst.match_cnt - b, post + 1);
    apb(1'b1, `OFS_CONTROL, 32'(post << 3));
    rdc(`OFS_IRQ_FLAGS, 32'h2);
    rdc(`OFS_IRQ_FLAGS, 32'h0);
    chk_v(32'(irq), 32'h0);
    apb(1'b0, `OFS_COUNT, 32'h0);
    v = rd;
    b = pwm_base_watch_inst.match_cnt;
    repeat (40) @(posedge clk);
    rdc(`OFS_COUNT, v);
    apb(1'b1, `OFS_CONTROL, 32'(post << 3));
    rdc(`OFS_COUNT, v);
    chk_n(pwm_base_watch_inst.match_cnt, b);
    apb(1'b1, `OFS_IRQ_ENAB, 32'h0);
    apb(1'b1, `OFS_CONTROL, 32'(post << 3 | 4));
    wait_m(post + 2);
    chk_v(32'(irq), 32'h0);
    apb(1'b1, `OFS_CONTROL, 32'h0);
    apb(1'b1, `OFS_IRQ_ENAB, 32'h2);
    @(negedge clk);
    chk_v(32'(irq), 32'h1);
    apb(1'b1, `OFS_IRQ_FLAGS, 32'h0);
    @(negedge clk);
    chk_v(32'(irq), 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk_v(rd, 32'h0);
    chk_v(32'(se), 32'h1);
    chk_n(pwm_base_watch_inst.shift_err, 0);
    tally_and_finish();
  end
endmodule : tb_top
